// [bcmc_defines.svh]
// Offsets, field positions, reset values and timing counts for the converter control
`ifndef BCMC_DEFINES_SVH
`define BCMC_DEFINES_SVH
`define BCMC_ADDR_CTRL_A 4'h0
`define BCMC_ADDR_CTRL_B 4'h1
`define BCMC_ADDR_MAIN_V 4'h2
`define BCMC_ADDR_CORE_V 4'h3
`define BCMC_ADDR_STATUS 4'h4
`define BCMC_A_FPWM 7
`define BCMC_A_SLEEP_EN 6
`define BCMC_A_MAIN_DIS 5
`define BCMC_A_MAIN_EN 4
`define BCMC_A_CORE_EN 3
`define BCMC_B_CORE_DIS 7
`define BCMC_B_SLEEP_OFF 6
`define BCMC_A_RESET 8'h18
`define BCMC_B_RESET 8'h04
`define BCMC_SLEEP_V_RESET 8'h0C
`define BCMC_SLEEP_V_BASE 8'h08
`define BCMC_MAIN_V_LO 8'h1E
`define BCMC_MAIN_V_HI 8'h21
`define BCMC_CORE_V_LO 8'h0F
`define BCMC_CORE_V_HI 8'h12
`define BCMC_CLK_HZ 25000000
`define BCMC_SW_HZ 1250000
`define BCMC_SS_STEPS 4
`define BCMC_SS_CYCLES 64
`endif

// [bcmc_phase.sv]
// One power stage: switching phase, mode sequencing and soft start
`include "bcmc_defines.svh"
module bcmc_phase #(
  parameter int PERIOD = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic tick,
  input wire logic fpwm,
  input wire logic comp_trip,
  input wire logic ilim_trip,
  input wire logic skip_low,
  input wire logic out_low,
  input wire logic out_high,
  input wire logic out_nominal_low,
  input wire logic dropout,
  output logic hs_on,
  output logic ls_on,
  output logic [1:0] ilim_step,
  output logic in_pfm
);
  initial begin
    if (PERIOD < 4) $error("bcmc_phase: period too short");
  end
  bcmc_pkg::bcmc_mode_t mode_ff, nxt_mode;
  logic half_ff;
  logic hs_ff, dead_ff, ls_ff;
  logic [7:0] ss_cnt_ff;
  logic [1:0] step_ff;
  // Half-rate start flag for PFM bursts
  logic start_pulse;
  assign start_pulse = tick && (mode_ff != bcmc_pkg::BCMC_PFM_RUN || half_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_ff <= 1'b0;
    end else if (tick) begin
      half_ff <= ~half_ff;
    end
  end

  // Mode sequencing
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      bcmc_pkg::BCMC_PWM: begin
        if (dropout) nxt_mode = bcmc_pkg::BCMC_FULL_ON; // R15
        else if (!fpwm && skip_low) nxt_mode = bcmc_pkg::BCMC_PFM_IDLE; // R10
      end
      bcmc_pkg::BCMC_PFM_IDLE: begin
        if (fpwm || out_nominal_low) nxt_mode = bcmc_pkg::BCMC_PWM; // R12
        else if (out_low) nxt_mode = bcmc_pkg::BCMC_PFM_RUN; // R11
      end
      bcmc_pkg::BCMC_PFM_RUN: begin
        if (fpwm || out_nominal_low) nxt_mode = bcmc_pkg::BCMC_PWM; // R12
        else if (out_high) nxt_mode = bcmc_pkg::BCMC_PFM_IDLE; // R11
      end
      bcmc_pkg::BCMC_FULL_ON: begin
        if (!dropout) nxt_mode = bcmc_pkg::BCMC_PWM;
      end
      default: nxt_mode = bcmc_pkg::BCMC_PWM;
    endcase
  end

  // Forced PWM takes effect on a switching tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= bcmc_pkg::BCMC_PWM;
    end else if (!enable) begin
      mode_ff <= bcmc_pkg::BCMC_PWM;
    end else if (tick || nxt_mode == bcmc_pkg::BCMC_PFM_IDLE
                 || nxt_mode == bcmc_pkg::BCMC_PFM_RUN) begin
      // Full-on stays reachable under forced PWM: it is PWM at 100% duty
      mode_ff <= nxt_mode; // R13 R18
    end
  end

  // Switch pair: tick turns rectifier off and switch on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_ff <= 1'b0;
      dead_ff <= 1'b0;
      ls_ff <= 1'b0;
    end else if (!enable || mode_ff == bcmc_pkg::BCMC_PFM_IDLE) begin
      hs_ff <= 1'b0;
      dead_ff <= 1'b0;
      ls_ff <= 1'b0;
    end else if (mode_ff == bcmc_pkg::BCMC_FULL_ON) begin
      hs_ff <= 1'b1; // R15
      ls_ff <= 1'b0;
      dead_ff <= 1'b0;
    end else if (start_pulse) begin
      hs_ff <= 1'b1; // R8
      ls_ff <= 1'b0;
      dead_ff <= 1'b0;
    end else if (hs_ff && (comp_trip || ilim_trip)) begin
      hs_ff <= 1'b0; // R8
      dead_ff <= 1'b1;
    end else if (dead_ff) begin
      dead_ff <= 1'b0;
      ls_ff <= 1'b1; // R8
    end
  end
  assign hs_on = hs_ff;
  assign ls_on = ls_ff;
  assign in_pfm = mode_ff[0];

  // Four-step current limit ramp
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ss_cnt_ff <= 8'h00;
      step_ff <= 2'h0;
    end else if (!enable) begin
      ss_cnt_ff <= 8'h00;
      step_ff <= 2'h0;
    end else if (step_ff != 2'(`BCMC_SS_STEPS - 1)) begin
      // Counter restarts per step so steps 0 to 2 each last 64 cycles; step 3 holds
      if (ss_cnt_ff == 8'(`BCMC_SS_CYCLES - 1)) begin
        ss_cnt_ff <= 8'h00;
        step_ff <= step_ff + 2'h1; // R14
      end else begin
        ss_cnt_ff <= ss_cnt_ff + 8'h01;
      end
    end
  end
  assign ilim_step = step_ff;

  ss_done_a: assert property (@(posedge clk) disable iff (rst)
    enable && step_ff == 2'h3 |=> step_ff == 2'h3 || !enable)
    else $error("soft start step fell back"); // R14
  fpwm_mode_a: assert property (@(posedge clk) disable iff (rst)
    fpwm && tick && enable |=> mode_ff == bcmc_pkg::BCMC_PWM
    || mode_ff == bcmc_pkg::BCMC_FULL_ON)
    else $error("forced pwm not honoured"); // R13
  no_shoot_a: assert property (@(posedge clk) disable iff (rst)
    !(hs_on && ls_on)) else $error("switch and rectifier both on"); // R8
  idle_off_a: assert property (@(posedge clk) disable iff (rst)
    mode_ff == bcmc_pkg::BCMC_PFM_IDLE |=> !hs_on || !enable
    || mode_ff != bcmc_pkg::BCMC_PFM_IDLE)
    else $error("switching in pfm idle"); // R11
  pfm_c: cover property (@(posedge clk) mode_ff == bcmc_pkg::BCMC_PFM_RUN);
endmodule

// [bcmc_pkg.sv]
// Types shared by the converter control files
package bcmc_pkg;
  // Gray order along PWM, idle, burst; bit 0 marks power-save
  typedef enum logic [1:0] {
    BCMC_PWM = 2'b00,
    BCMC_PFM_IDLE = 2'b01,
    BCMC_PFM_RUN = 2'b11,
    BCMC_FULL_ON = 2'b10
  } bcmc_mode_t;
endpackage

// [bcmc_stage_model.sv]
// Behavioural power stages: comparator trips a few cycles into each on-time
module bcmc_stage_model #(
  parameter int ON_CYC = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] hs_on,
  output logic [1:0] comp_trip
);
  int cnt_ff [2];

  // Inductor ramp per stage; trip holds until the switch opens
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff[0] <= 0;
      cnt_ff[1] <= 0;
      comp_trip <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        cnt_ff[i] <= hs_on[i] ? cnt_ff[i] + 1 : 0;
        comp_trip[i] <= hs_on[i] && (cnt_ff[i] >= ON_CYC - 1);
      end
    end
  end
endmodule

// [bcmc_top.sv]
// Dual step-down converter digital mode and voltage control
// Notes on behaviour
// [R1] Main target resets to 3 V or 3.3 V by its strap.
// [R2] Core target resets to 1.5 V or 1.8 V by its strap.
// [R3] Host may overwrite both targets through control registers.
// [R4] Active sleep request lowers core voltage or disables core, as set.
// [R5] Sleep request ignored unless sleep enable bit is set.
// [R6] Power-good of an enabled converter readable by host.
// [R7] Fixed 1.25 MHz PWM at load, power-save at light load.
// [R8] Tick: rectifier off, switch on; trip off; rectifier after dead time.
// [R9] Core switch turn-on lags main by 270 degrees.
// [R10] Low average current in PWM enters power-save.
// [R11] Power-save bursts at half rate below low, stop at high.
// [R12] Output below nominal in power-save returns to PWM.
// [R13] Forced PWM bit 7 keeps both converters out of power-save.
// [R14] Current limit ramps in four steps at start-up.
// [R15] Input near output holds switch fully on.
// [R16] Fault-disabled output discharged only when its bit set; bits clear.
// [R17] Power-good comparator disabled while converter disabled.
// [R18] Forced PWM returns power-save converter to PWM next tick.
//
// The implementer's own choices: the plain strobed port and the address map.
`include "bcmc_defines.svh"
module bcmc_top #(
  parameter int CLK_HZ = `BCMC_CLK_HZ,
  parameter int SW_HZ = `BCMC_SW_HZ
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic MAIN_DEFAULT_SELECT_PIN,
  input wire logic CORE_DEFAULT_SELECT_PIN,
  input wire logic DEEP_SLEEP_REQUEST_PIN,
  input wire logic UNDERVOLTAGE_LOCKOUT,
  input wire logic BATTERY_COVER_OPEN,
  input wire logic OVERTEMP,
  input wire logic [1:0] COMP_TRIP,
  input wire logic [1:0] ILIM_TRIP,
  input wire logic [1:0] SKIP_LOW,
  input wire logic [1:0] OUT_LOW,
  input wire logic [1:0] OUT_HIGH,
  input wire logic [1:0] OUT_NOMINAL_LOW,
  input wire logic [1:0] DROPOUT,
  input wire logic [1:0] PGOOD_RAW,
  output logic [1:0] HS_ON,
  output logic [1:0] LS_ON,
  output logic [3:0] ILIM_STEP,
  output logic [1:0] PGOOD_COMP_EN,
  output logic [1:0] DISCHARGE_ON,
  output logic [7:0] MAIN_RAIL_TARGET,
  output logic [7:0] CORE_RAIL_TARGET
);
  localparam int PERIOD = CLK_HZ / SW_HZ;
  localparam int LAG = (PERIOD * 270) / 360;
  initial begin
    if (PERIOD < 4 || PERIOD > 255) $error("bcmc_top: bad switching ratio");
  end

  // Pin synchronisers: pins come from outside the clock domain
  // Bit 8 is a constant marker: high once both flops hold real pins
  logic [10:0] pin_s1_ff, pin_s2_ff;
  logic [10:0] pins;
  assign pins = {PGOOD_RAW, 1'b1, DROPOUT, MAIN_DEFAULT_SELECT_PIN,
                 CORE_DEFAULT_SELECT_PIN, DEEP_SLEEP_REQUEST_PIN,
                 OVERTEMP, BATTERY_COVER_OPEN, UNDERVOLTAGE_LOCKOUT};
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_s1_ff <= 11'h000;
      pin_s2_ff <= 11'h000;
    end else begin
      pin_s1_ff <= pins;
      pin_s2_ff <= pin_s1_ff;
    end
  end
  logic fault_s, sleep_s, core_sel_s, main_sel_s;
  logic [1:0] drop_s, pg_s;
  // Fault sources merged only after synchronising
  assign fault_s = |pin_s2_ff[2:0];
  assign sleep_s = pin_s2_ff[3];
  assign core_sel_s = pin_s2_ff[4];
  assign main_sel_s = pin_s2_ff[5];
  assign drop_s = pin_s2_ff[7:6];
  assign pg_s = pin_s2_ff[10:9];

  // Straps caught once after reset release
  logic strap_done_ff;
  logic [7:0] ctrl_a_ff, ctrl_b_ff, main_v_ff, core_v_ff, sleep_v_ff;
  logic wr_a, wr_b, wr_m, wr_c;
  assign wr_a = WR && ADDR == `BCMC_ADDR_CTRL_A;
  assign wr_b = WR && ADDR == `BCMC_ADDR_CTRL_B;
  assign wr_m = WR && ADDR == `BCMC_ADDR_MAIN_V;
  assign wr_c = WR && ADDR == `BCMC_ADDR_CORE_V;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      strap_done_ff <= 1'b0;
    end else if (pin_s2_ff[8] && !strap_done_ff) begin
      strap_done_ff <= 1'b1;
    end
  end

  // Target voltage registers, straps first then host
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      main_v_ff <= `BCMC_MAIN_V_LO;
      core_v_ff <= `BCMC_CORE_V_LO;
    end else if (!strap_done_ff) begin
      main_v_ff <= main_sel_s ? `BCMC_MAIN_V_HI : `BCMC_MAIN_V_LO; // R1
      core_v_ff <= core_sel_s ? `BCMC_CORE_V_HI : `BCMC_CORE_V_LO; // R2
    end else begin
      if (wr_m) main_v_ff <= WDATA; // R3
      if (wr_c) core_v_ff <= WDATA; // R3
    end
  end

  // Control registers; discharge bits clear at reset
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_a_ff <= `BCMC_A_RESET; // R16
      ctrl_b_ff <= `BCMC_B_RESET; // R16
      sleep_v_ff <= `BCMC_SLEEP_V_RESET;
    end else begin
      if (wr_a) ctrl_a_ff <= WDATA;
      if (wr_b) ctrl_b_ff <= WDATA;
      if (wr_b) sleep_v_ff <= {3'h0, WDATA[4:0]} + `BCMC_SLEEP_V_BASE;
    end
  end

  // Sleep request gated by enable bit
  logic sleep_act, main_en, core_en;
  assign sleep_act = sleep_s && ctrl_a_ff[`BCMC_A_SLEEP_EN]; // R5
  assign main_en = ctrl_a_ff[`BCMC_A_MAIN_EN] && !fault_s;
  assign core_en = ctrl_a_ff[`BCMC_A_CORE_EN] && !fault_s
                   && !(sleep_act && ctrl_b_ff[`BCMC_B_SLEEP_OFF]); // R4

  // Output targets as data outputs from flops
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      MAIN_RAIL_TARGET <= 8'h00;
      CORE_RAIL_TARGET <= 8'h00;
    end else begin
      MAIN_RAIL_TARGET <= main_v_ff;
      CORE_RAIL_TARGET <= sleep_act ? sleep_v_ff : core_v_ff; // R4
    end
  end

  // Master switching counter; core tick lags by 270 degrees
  logic [7:0] per_ff;
  logic main_tick, core_tick;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      per_ff <= 8'h00;
    end else if (per_ff == 8'(PERIOD - 1)) begin
      per_ff <= 8'h00; // R7
    end else begin
      per_ff <= per_ff + 8'h01;
    end
  end
  assign main_tick = per_ff == 8'h00; // R9
  assign core_tick = per_ff == 8'(LAG); // R9

  logic fpwm;
  logic [1:0] pfm;
  assign fpwm = ctrl_a_ff[`BCMC_A_FPWM]; // R13

  bcmc_phase #(.PERIOD(PERIOD)) u_main (
    .clk(REF_CLK), .rst(RST), .enable(main_en), .tick(main_tick),
    .fpwm(fpwm), .comp_trip(COMP_TRIP[0]), .ilim_trip(ILIM_TRIP[0]),
    .skip_low(SKIP_LOW[0]), .out_low(OUT_LOW[0]), .out_high(OUT_HIGH[0]),
    .out_nominal_low(OUT_NOMINAL_LOW[0]), .dropout(drop_s[0]),
    .hs_on(HS_ON[0]), .ls_on(LS_ON[0]), .ilim_step(ILIM_STEP[1:0]),
    .in_pfm(pfm[0]));
  bcmc_phase #(.PERIOD(PERIOD)) u_core (
    .clk(REF_CLK), .rst(RST), .enable(core_en), .tick(core_tick),
    .fpwm(fpwm), .comp_trip(COMP_TRIP[1]), .ilim_trip(ILIM_TRIP[1]),
    .skip_low(SKIP_LOW[1]), .out_low(OUT_LOW[1]), .out_high(OUT_HIGH[1]),
    .out_nominal_low(OUT_NOMINAL_LOW[1]), .dropout(drop_s[1]),
    .hs_on(HS_ON[1]), .ls_on(LS_ON[1]), .ilim_step(ILIM_STEP[3:2]),
    .in_pfm(pfm[1]));

  // Comparator enables and discharge
  assign PGOOD_COMP_EN = {core_en, main_en}; // R17
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      DISCHARGE_ON <= 2'h0;
    end else begin
      DISCHARGE_ON[0] <= fault_s && ctrl_a_ff[`BCMC_A_MAIN_DIS]; // R16
      DISCHARGE_ON[1] <= fault_s && ctrl_b_ff[`BCMC_B_CORE_DIS]; // R16
    end
  end

  // Read port, data one cycle after strobe
  logic [7:0] status;
  assign status = {2'h0, pfm, sleep_act, fault_s,
                   pg_s[1] & core_en, pg_s[0] & main_en}; // R6
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `BCMC_ADDR_CTRL_A: RDATA <= ctrl_a_ff;
        `BCMC_ADDR_CTRL_B: RDATA <= ctrl_b_ff;
        `BCMC_ADDR_MAIN_V: RDATA <= main_v_ff;
        `BCMC_ADDR_CORE_V: RDATA <= core_v_ff;
        `BCMC_ADDR_STATUS: RDATA <= status;
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  sleep_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !ctrl_a_ff[`BCMC_A_SLEEP_EN] |=> CORE_RAIL_TARGET == $past(core_v_ff))
    else $error("sleep request not ignored"); // R5
  lag_a: assert property (@(posedge REF_CLK) disable iff (RST)
    main_tick |-> ##(LAG) core_tick) else $error("core lag wrong"); // R9
  pg_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !main_en |-> !status[0] && !PGOOD_COMP_EN[0])
    else $error("pgood with main off"); // R17
  dis_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !fault_s |=> DISCHARGE_ON == 2'h0) else $error("discharge no fault"); // R16
  sleep_c: cover property (@(posedge REF_CLK) sleep_act);
  dis_c: cover property (@(posedge REF_CLK) DISCHARGE_ON[1]);
endmodule

// [bcmc_top_test.sv]
// Self-checking bench for the dual converter mode control
`include "bcmc_defines.svh"
module bcmc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = `BCMC_CLK_HZ / `BCMC_SW_HZ;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] RDATA;
  logic MSEL = 1'b0;
  logic CSEL = 1'b0;
  logic SLEEP = 1'b0;
  logic [2:0] FAULT = 3'h0;
  logic [1:0] COMP_TRIP;
  logic [1:0] ILIM = 2'h0;
  logic [1:0] SKIP_LOW = 2'h0;
  logic [1:0] OUT_LOW = 2'h0;
  logic [1:0] OUT_HIGH = 2'h0;
  logic [1:0] OUT_NOM = 2'h0;
  logic [1:0] DROPOUT = 2'h0;
  logic [1:0] PGOOD_RAW = 2'h0;
  logic [1:0] HS_ON, LS_ON, PGOOD_COMP_EN, DISCHARGE_ON;
  logic [3:0] ILIM_STEP;
  logic [7:0] MAIN_T, CORE_T;
  int error_cnt = 0;
  int n_compared = 0;

  // Free-running converter clock
  always #20 REF_CLK = ~REF_CLK;

  bcmc_top uut (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .MAIN_DEFAULT_SELECT_PIN(MSEL),
    .CORE_DEFAULT_SELECT_PIN(CSEL), .DEEP_SLEEP_REQUEST_PIN(SLEEP),
    .UNDERVOLTAGE_LOCKOUT(FAULT[0]), .BATTERY_COVER_OPEN(FAULT[1]),
    .OVERTEMP(FAULT[2]), .COMP_TRIP(COMP_TRIP), .ILIM_TRIP(ILIM),
    .SKIP_LOW(SKIP_LOW), .OUT_LOW(OUT_LOW), .OUT_HIGH(OUT_HIGH),
    .OUT_NOMINAL_LOW(OUT_NOM), .DROPOUT(DROPOUT), .PGOOD_RAW(PGOOD_RAW),
    .HS_ON(HS_ON), .LS_ON(LS_ON), .ILIM_STEP(ILIM_STEP),
    .PGOOD_COMP_EN(PGOOD_COMP_EN), .DISCHARGE_ON(DISCHARGE_ON),
    .MAIN_RAIL_TARGET(MAIN_T), .CORE_RAIL_TARGET(CORE_T));

  bcmc_stage_model stage (.clk(REF_CLK), .rst(RST), .hs_on(HS_ON),
    .comp_trip(COMP_TRIP));

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Inputs move 1 ns after an edge so no sampling race exists
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  // Bounded wait for a switch turn-on; t counts the cycles taken
  task automatic wait_rise(input int i, output int t);
    logic p;
    t = 0;
    p = HS_ON[i];
    while (!(HS_ON[i] === 1'b1 && p === 1'b0)) begin
      p = HS_ON[i];
      wait_cyc(1);
      t++;
      if (t > 200) begin
        error_cnt++;
        $display("wrong value turn-on %0d expected rise seen none", i);
        print_verdict();
      end
    end
  endtask

  // Counts turn-ons, or cycles with the switch on, over n cycles
  task automatic count(input int i, input int n, input bit rise,
                       output int c);
    logic p;
    c = 0;
    p = HS_ON[i];
    repeat (n) begin
      wait_cyc(1);
      if (HS_ON[i] === 1'b1 && (!rise || p === 1'b0)) c++;
      p = HS_ON[i];
    end
  endtask

  // Switch and rectifier of one stage never conduct together
  always @(negedge REF_CLK) begin
    if (!RST && (HS_ON & LS_ON) !== 2'h0) begin
      chk("overlap", {6'h0, HS_ON & LS_ON}, 8'h00);
    end
  end

  initial begin
    int t, c;
    logic [7:0] d;
    // Straps low then high, each set while a fresh reset is held
    for (int s = 0; s < 2; s++) begin
      RST <= 1'b1;
      MSEL <= s[0];
      CSEL <= s[0];
      wait_cyc(3);
      RST <= 1'b0;
      wait_cyc(8);
      chk("main", MAIN_T, s ? `BCMC_MAIN_V_HI : `BCMC_MAIN_V_LO);
      chk("core", CORE_T, s ? `BCMC_CORE_V_HI : `BCMC_CORE_V_LO);
      chk("ilim early", {4'h0, ILIM_STEP} == 8'h0F, 8'h00);
      rd(`BCMC_ADDR_CTRL_A, d);
      chk("ctrl_a", d, `BCMC_A_RESET);
      rd(`BCMC_ADDR_CTRL_B, d);
      chk("ctrl_b", d, `BCMC_B_RESET);
      chk("dis", {6'h0, DISCHARGE_ON}, 8'h00);
      wait_cyc(`BCMC_SS_STEPS * `BCMC_SS_CYCLES);
      chk("ilim final", {4'h0, ILIM_STEP}, 8'h0F);
    end
    $display("test reset done");
    wait_rise(0, t);
    wait_rise(1, t);
    chk("lag", 8'(t), 8'(PER * 270 / 360));
    wait_rise(0, t);
    chk("period", 8'(t), 8'(PER - PER * 270 / 360));
    // Current limit held tripped: switch lasts one cycle per period
    ILIM <= 2'h1;
    wait_rise(0, t);
    count(0, PER, 1'b0, c);
    chk("ilim cut", 8'(c), 8'h01);
    ILIM <= 2'h0;
    $display("test phase done");
    SKIP_LOW <= 2'h1;
    OUT_LOW <= 2'h1;
    wait_cyc(60);
    rd(`BCMC_ADDR_STATUS, d);
    chk("pfm in", d & 8'h30, 8'h10);
    count(0, 4 * PER, 1'b1, c);
    chk("burst", 8'(c), 8'h02);
    OUT_LOW <= 2'h0;
    OUT_HIGH <= 2'h1;
    wait_cyc(5);
    count(0, 4 * PER, 1'b1, c);
    chk("idle", 8'(c), 8'h00);
    OUT_HIGH <= 2'h0;
    OUT_NOM <= 2'h1;
    SKIP_LOW <= 2'h0;
    // Return to PWM waits for the next switching tick
    wait_cyc(PER);
    rd(`BCMC_ADDR_STATUS, d);
    chk("pfm out", d & 8'h30, 8'h00);
    count(0, 4 * PER, 1'b1, c);
    chk("pwm", 8'(c), 8'h04);
    OUT_NOM <= 2'h0;
    wr(`BCMC_ADDR_CTRL_A, 8'h98);
    SKIP_LOW <= 2'h3;
    wait_cyc(60);
    rd(`BCMC_ADDR_STATUS, d);
    chk("fpwm", d & 8'h30, 8'h00);
    wr(`BCMC_ADDR_CTRL_A, 8'h18);
    wait_cyc(60);
    rd(`BCMC_ADDR_STATUS, d);
    chk("pfm both", d & 8'h30, 8'h30);
    wr(`BCMC_ADDR_CTRL_A, 8'h98);
    wait_cyc(PER + 1);
    rd(`BCMC_ADDR_STATUS, d);
    chk("fpwm exit", d & 8'h30, 8'h00);
    SKIP_LOW <= 2'h0;
    DROPOUT <= 2'h1;
    wait_cyc(30);
    count(0, 2 * PER, 1'b0, c);
    chk("full on", 8'(c), 8'(2 * PER));
    DROPOUT <= 2'h0;
    $display("test mode done");
    SLEEP <= 1'b1;
    wait_cyc(5);
    chk("sleep off", CORE_T, `BCMC_CORE_V_HI);
    wr(`BCMC_ADDR_CTRL_A, 8'h58);
    wait_cyc(5);
    chk("sleep v", CORE_T, 8'h0C);
    wr(`BCMC_ADDR_CTRL_B, 8'h44);
    wait_cyc(5);
    chk("sleep dis", {6'h0, PGOOD_COMP_EN}, 8'h01);
    SLEEP <= 1'b0;
    wr(`BCMC_ADDR_CTRL_B, 8'h04);
    wr(`BCMC_ADDR_CTRL_A, 8'h18);
    wr(`BCMC_ADDR_MAIN_V, 8'h1C);
    wr(`BCMC_ADDR_CORE_V, 8'h0E);
    wait_cyc(2);
    chk("main wr", MAIN_T, 8'h1C);
    rd(`BCMC_ADDR_CORE_V, d);
    chk("core wr", d, 8'h0E);
    rd(4'hF, d);
    chk("unmapped", d, 8'h00);
    $display("test voltage done");
    PGOOD_RAW <= 2'h3;
    wait_cyc(5);
    rd(`BCMC_ADDR_STATUS, d);
    chk("pg", d & 8'h03, 8'h03);
    wr(`BCMC_ADDR_CTRL_A, 8'h08);
    wait_cyc(5);
    chk("pg en", {6'h0, PGOOD_COMP_EN}, 8'h02);
    rd(`BCMC_ADDR_STATUS, d);
    chk("pg off", d & 8'h03, 8'h02);
    wr(`BCMC_ADDR_CTRL_A, 8'h18);
    $display("test power good done");
    // Each fault source, first with discharge off, then on
    for (int k = 0; k < 3; k++) begin
      FAULT <= 3'h1 << k;
      wait_cyc(5);
      chk("no dis", {6'h0, DISCHARGE_ON}, 8'h00);
      wr(`BCMC_ADDR_CTRL_A, 8'h38);
      wr(`BCMC_ADDR_CTRL_B, 8'h84);
      wait_cyc(5);
      chk("dis", {6'h0, DISCHARGE_ON}, 8'h03);
      rd(`BCMC_ADDR_STATUS, d);
      chk("fault", d & 8'h04, 8'h04);
      FAULT <= 3'h0;
      wr(`BCMC_ADDR_CTRL_A, 8'h18);
      wr(`BCMC_ADDR_CTRL_B, 8'h04);
    end
    $display("test discharge done");
    print_verdict();
  end
endmodule
